// [core/pdr_pkg.sv]
// Shared constants, enumerations and carriers of the pump drive remote I/O block.
// Assumes a single 10 MHz clock; speeds are in tenths of a percent of nominal.
package pdr_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD = 9600;
  localparam int BAUD_CYC = CLK_HZ / BAUD;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int ACK_MIN_MS = 500;
  localparam int ACK_MAX_MS = 2000;
  localparam int ACK_MIN_CYC = ACK_MIN_MS * (CLK_HZ / 1000);
  localparam int ACK_MAX_CYC = ACK_MAX_MS * (CLK_HZ / 1000);
  localparam logic [9:0] GROUP_ADDR = 10'h3C1;
  localparam logic [9:0] FULL_SCALE = 10'h3E8;
  localparam logic [9:0] STBY_SPD_RST = 10'h29B;
  localparam logic [9:0] SWITCH_PT_RST = 10'h320;
  localparam logic [9:0] DEV_ADDR_RST = 10'h001;
  localparam logic [7:0] TELEGRAM_END = 8'h0D;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ACK = 4'h1;
  localparam logic [3:0] OFS_DI_CFG = 4'h2;
  localparam logic [3:0] OFS_DO_CFG = 4'h3;
  localparam logic [3:0] OFS_AO_CFG = 4'h4;
  localparam logic [3:0] OFS_SWITCH_PT = 4'h5;
  localparam logic [3:0] OFS_STBY_SPD = 4'h6;
  localparam logic [3:0] OFS_VENT_MODE = 4'h7;
  localparam logic [3:0] OFS_DEV_ADDR = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;
  localparam logic [3:0] OFS_ERR_PEND = 4'hA;
  localparam logic [3:0] OFS_RX = 4'hB;
  localparam logic [3:0] OFS_TX = 4'hC;
  localparam int RX_VALID_BIT = 8;
  localparam int RX_HIT_BIT = 9;

  typedef enum logic [1:0] {DI_VENT = 2'h0, DI_HEAT = 2'h1, DI_NONE = 2'h2} pdr_di_fn_t;
  typedef enum logic [3:0] {
    DO_SPEED_PT = 4'h0, DO_NO_ERR = 4'h1, DO_ERR = 4'h2, DO_ZERO = 4'h9, DO_ONE = 4'hA,
    DO_REMOTE = 4'hB, DO_HEAT = 4'hC, DO_PUMP_STN = 4'hF
  } pdr_do_fn_t;
  typedef enum logic [1:0] {AO_SPEED = 2'h0, AO_CURRENT = 2'h1, AO_POWER = 2'h2} pdr_ao_fn_t;
  typedef enum logic [1:0] {VENT_ON_STOP = 2'h0, VENT_NEVER = 2'h1, VENT_ALWAYS = 2'h2} pdr_vent_t;
  typedef enum logic [1:0] {SER_IDLE = 2'b00, SER_START = 2'b01, SER_DATA = 2'b11, SER_STOP = 2'b10} pdr_ser_st_t;
  typedef enum logic [1:0] {ADR_WAIT = 2'b00, ADR_D0 = 2'b01, ADR_D1 = 2'b11, ADR_D2 = 2'b10} pdr_adr_st_t;

  localparam pdr_di_fn_t DI1_RST = DI_VENT;
  localparam pdr_di_fn_t DI2_RST = DI_HEAT;
  localparam pdr_do_fn_t DO1_RST = DO_SPEED_PT;
  localparam pdr_do_fn_t DO2_RST = DO_NO_ERR;

  typedef struct packed {
    logic remote_priority;
    logic venting_enable_input;
    logic heating_input;
    logic pump_station;
    logic standby_ack;
  } pdr_pins_t;

  typedef struct packed {
    logic vent_enable;
    logic pump_station;
    logic standby;
    logic heat;
  } pdr_cmd_t;
endpackage

// [core/pdr_sync.sv]
// Three-stage input synchroniser with agreement filter for asynchronous pins.
// Assumes inputs may change at any time relative to mclk.
`timescale 1ns/100ps
module pdr_sync #(
  parameter int W = 6
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change taken only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          level[i] <= 1'b0;
        end else if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule

// [core/pdr_uart.sv]
// Half-duplex serial character engine: 8 data bits, no parity, one start, one stop.
// Assumes rx is already synchronised to mclk; drive_n is low while transmitting.
`timescale 1ns/100ps
module pdr_uart #(
  parameter int DIV = pdr_pkg::BAUD_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rx,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic rx_strobe,
  output logic tx_line,
  output logic drive_n,
  output logic busy
);
  localparam logic [15:0] CNT_END = 16'(DIV - 1);
  localparam logic [15:0] CNT_HALF = 16'(DIV / 2 - 1);
  localparam logic [2:0] LAST_BIT = 3'(pdr_pkg::DATA_BITS - 1);

  pdr_pkg::pdr_ser_st_t tx_st;
  pdr_pkg::pdr_ser_st_t rx_st;
  logic [15:0] tx_cnt;
  logic [15:0] rx_cnt;
  logic [2:0] tx_bit;
  logic [2:0] rx_bit;
  logic [7:0] tx_sh;

  assign busy = (tx_st != pdr_pkg::SER_IDLE);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_st <= pdr_pkg::SER_IDLE;
      tx_cnt <= 16'h0000;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      tx_line <= 1'b1;
      drive_n <= 1'b1;
    end else begin
      tx_cnt <= (tx_cnt == CNT_END) ? 16'h0000 : tx_cnt + 16'h0001;
      case (tx_st)
        pdr_pkg::SER_IDLE: begin
          tx_cnt <= 16'h0000;
          if (tx_start) begin
            tx_sh <= tx_byte;
            tx_line <= 1'b0;
            drive_n <= 1'b0;
            tx_st <= pdr_pkg::SER_START;
          end
        end
        pdr_pkg::SER_START: begin
          if (tx_cnt == CNT_END) begin
            tx_line <= tx_sh[0];
            tx_sh <= tx_sh >> 1;
            tx_bit <= 3'h0;
            tx_st <= pdr_pkg::SER_DATA;
          end
        end
        pdr_pkg::SER_DATA: begin
          if (tx_cnt == CNT_END) begin
            if (tx_bit == LAST_BIT) begin
              tx_line <= 1'b1;
              tx_st <= pdr_pkg::SER_STOP;
            end else begin
              tx_line <= tx_sh[0];
              tx_sh <= tx_sh >> 1;
              tx_bit <= tx_bit + 3'h1;
            end
          end
        end
        pdr_pkg::SER_STOP: begin
          if (tx_cnt == CNT_END) begin
            drive_n <= 1'b1;
            tx_st <= pdr_pkg::SER_IDLE;
          end
        end
        default: tx_st <= pdr_pkg::SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_st <= pdr_pkg::SER_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_byte <= 8'h00;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= 1'b0;
      rx_cnt <= (rx_cnt == CNT_END) ? 16'h0000 : rx_cnt + 16'h0001;
      case (rx_st)
        pdr_pkg::SER_IDLE: begin
          rx_cnt <= 16'h0000;
          if (!rx) begin
            rx_st <= pdr_pkg::SER_START;
          end
        end
        pdr_pkg::SER_START: begin
          if (rx_cnt == CNT_HALF) begin
            rx_cnt <= 16'h0000;
            rx_bit <= 3'h0;
            rx_st <= rx ? pdr_pkg::SER_IDLE : pdr_pkg::SER_DATA;
          end
        end
        pdr_pkg::SER_DATA: begin
          if (rx_cnt == CNT_END) begin
            rx_byte <= {rx, rx_byte[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == LAST_BIT) begin
              rx_st <= pdr_pkg::SER_STOP;
            end
          end
        end
        pdr_pkg::SER_STOP: begin
          // Framing error drops the character silently
          if (rx_cnt == CNT_END) begin
            rx_strobe <= rx;
            rx_st <= pdr_pkg::SER_IDLE;
          end
        end
        default: rx_st <= pdr_pkg::SER_IDLE;
      endcase
    end
  end
endmodule

// [core/pdr_top.sv]
// Remote-control I/O of a turbopump drive: command pins, status outputs,
// analog speed output and serial parameter link.
// Assumes rotor speed, current, power and error causes come from the drive core.
// Operation
// - Remote priority high: pin commands override parameter commands.
// - Venting enable high permits venting per mode; low locks venting.
// - Heating follows the heating command level.
// - Pumping station high starts pump and station accessories; low stops.
// - Pumping station rising edge clears errors whose cause is gone.
// - Standby high runs at standby speed; low returns to nominal.
// - Standby speed defaults to 66.7 percent of nominal.
// - Standby pin pulse of 500 to 2000 ms acknowledges errors.
// - Two configurable inputs default to venting and heating, reassignable.
// - First output high at speed switch point, default 80 percent.
// - Second output high when no error, low on any error.
// - Both digital outputs have defaults and are reassignable.
// - Cooling accessory output switches on the air cooling unit.
// - Vent valve output active only with venting release given.
// - Analog output linear in speed, full scale nominal; current or power selectable.
// - Serial link 9600 baud, 8 data bits, no parity, one start.
// - Telegrams to own address or group address 961 are accepted.
// - Operating variables held as numbered parameters, reachable serially; here held at register offsets, serial only passes characters.
`timescale 1ns/100ps
module pdr_top #(
  parameter int ACK_MIN_CYC = pdr_pkg::ACK_MIN_CYC,
  parameter int ACK_MAX_CYC = pdr_pkg::ACK_MAX_CYC,
  parameter int BAUD_DIV = pdr_pkg::BAUD_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire pdr_pkg::pdr_pins_t remote_connector,
  input wire logic rs485_rx,
  input wire logic [9:0] rotor_speed,
  input wire logic [9:0] motor_current,
  input wire logic [9:0] motor_power,
  input wire logic [7:0] error_cause,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic speed_point_output,
  output logic fault_free_output,
  output logic cooling_accessory_output,
  output logic vent_valve_accessory_output,
  output logic [9:0] speed_analog_output,
  output logic [9:0] speed_setpoint,
  output logic heating_on,
  output logic pump_motor_on,
  output logic rs485_tx,
  output logic rs485_drive_n
);
  localparam logic [24:0] ACK_LO = 25'(ACK_MIN_CYC);
  localparam logic [24:0] ACK_HI = 25'(ACK_MAX_CYC);
  localparam logic [24:0] ACK_SAT = 25'(ACK_MAX_CYC + 1);

  pdr_pkg::pdr_pins_t pins;
  logic rx_s;
  pdr_pkg::pdr_cmd_t par_cmd;
  pdr_pkg::pdr_cmd_t eff_cmd;
  pdr_pkg::pdr_di_fn_t di1_fn;
  pdr_pkg::pdr_di_fn_t di2_fn;
  pdr_pkg::pdr_do_fn_t do1_fn;
  pdr_pkg::pdr_do_fn_t do2_fn;
  pdr_pkg::pdr_ao_fn_t ao_fn;
  pdr_pkg::pdr_vent_t vent_mode;
  pdr_pkg::pdr_adr_st_t adr_st;
  logic [9:0] switch_pt;
  logic [9:0] stby_spd;
  logic [9:0] dev_addr;
  logic [7:0] err_pend;
  logic any_err;
  logic pump_prev;
  logic stby_prev;
  logic [24:0] stby_cnt;
  logic pulse_ack;
  logic sw_ack;
  logic ack;
  logic pin_vent;
  logic pin_heat;
  logic [7:0] rx_byte;
  logic rx_strobe;
  logic rx_valid;
  logic [7:0] rx_data;
  logic [9:0] adr_acc;
  logic [9:0] next_acc;
  logic addr_hit;
  logic tx_start;
  logic [7:0] tx_byte;
  logic tx_busy;
  logic tx_line;
  logic drive_n;
  logic [15:0] next_rdata;

  // Output function decode shared by both digital outputs
  function automatic logic do_value(input pdr_pkg::pdr_do_fn_t fn, input logic at_pt, input logic err,
                                    input logic prio, input logic heat, input logic stn);
    case (fn)
      pdr_pkg::DO_SPEED_PT: do_value = at_pt;
      pdr_pkg::DO_NO_ERR: do_value = !err;
      pdr_pkg::DO_ERR: do_value = err;
      pdr_pkg::DO_ONE: do_value = 1'b1;
      pdr_pkg::DO_REMOTE: do_value = prio;
      pdr_pkg::DO_HEAT: do_value = heat;
      pdr_pkg::DO_PUMP_STN: do_value = stn;
      default: do_value = 1'b0;
    endcase
  endfunction

  // Input function decode shared by both configurable inputs
  function automatic logic di_takes(input pdr_pkg::pdr_di_fn_t fn1, input logic lvl1,
                                    input pdr_pkg::pdr_di_fn_t fn2, input logic lvl2,
                                    input pdr_pkg::pdr_di_fn_t want);
    di_takes = ((fn1 == want) && lvl1) || ((fn2 == want) && lvl2);
  endfunction

  pdr_sync #(
    .W(6)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin({remote_connector, rs485_rx}),
    .level({pins, rx_s})
  );

  pdr_uart #(
    .DIV(BAUD_DIV)
  ) u_uart (
    .mclk(mclk),
    .reset_n(reset_n),
    .rx(rx_s),
    .tx_start(tx_start),
    .tx_byte(tx_byte),
    .rx_byte(rx_byte),
    .rx_strobe(rx_strobe),
    .tx_line(tx_line),
    .drive_n(drive_n),
    .busy(tx_busy)
  );

  assign pin_vent = di_takes(di1_fn, pins.venting_enable_input, di2_fn, pins.heating_input, pdr_pkg::DI_VENT);
  assign pin_heat = di_takes(di1_fn, pins.venting_enable_input, di2_fn, pins.heating_input, pdr_pkg::DI_HEAT);

  // Pin commands win under remote priority
  always_comb begin
    if (pins.remote_priority) begin
      eff_cmd.vent_enable = pin_vent;
      eff_cmd.pump_station = pins.pump_station;
      eff_cmd.standby = pins.standby_ack;
      eff_cmd.heat = pin_heat;
    end else begin
      eff_cmd = par_cmd;
    end
  end

  assign any_err = |err_pend;
  assign ack = pulse_ack || sw_ack || (eff_cmd.pump_station && !pump_prev);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      par_cmd <= '0;
      di1_fn <= pdr_pkg::DI1_RST;
      di2_fn <= pdr_pkg::DI2_RST;
      do1_fn <= pdr_pkg::DO1_RST;
      do2_fn <= pdr_pkg::DO2_RST;
      ao_fn <= pdr_pkg::AO_SPEED;
      vent_mode <= pdr_pkg::VENT_ON_STOP;
      switch_pt <= pdr_pkg::SWITCH_PT_RST;
      stby_spd <= pdr_pkg::STBY_SPD_RST;
      dev_addr <= pdr_pkg::DEV_ADDR_RST;
      sw_ack <= 1'b0;
      tx_start <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      sw_ack <= wr && (addr == pdr_pkg::OFS_ACK) && wdata[0];
      // A write while busy is dropped; software polls the busy bit
      tx_start <= wr && (addr == pdr_pkg::OFS_TX) && !tx_busy && !tx_start;
      if (wr) begin
        case (addr)
          pdr_pkg::OFS_CTRL: par_cmd <= wdata[3:0];
          pdr_pkg::OFS_DI_CFG: begin
            di1_fn <= pdr_pkg::pdr_di_fn_t'(wdata[1:0]);
            di2_fn <= pdr_pkg::pdr_di_fn_t'(wdata[3:2]);
          end
          pdr_pkg::OFS_DO_CFG: begin
            do1_fn <= pdr_pkg::pdr_do_fn_t'(wdata[3:0]);
            do2_fn <= pdr_pkg::pdr_do_fn_t'(wdata[7:4]);
          end
          pdr_pkg::OFS_AO_CFG: ao_fn <= pdr_pkg::pdr_ao_fn_t'(wdata[1:0]);
          pdr_pkg::OFS_SWITCH_PT: switch_pt <= wdata[9:0];
          pdr_pkg::OFS_STBY_SPD: stby_spd <= wdata[9:0];
          pdr_pkg::OFS_VENT_MODE: vent_mode <= pdr_pkg::pdr_vent_t'(wdata[1:0]);
          pdr_pkg::OFS_DEV_ADDR: dev_addr <= wdata[9:0];
          pdr_pkg::OFS_TX: tx_byte <= tx_busy ? tx_byte : wdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Pulse width measured on the standby pin
  // Over-long level saturates and never acknowledges
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stby_prev <= 1'b0;
      stby_cnt <= 25'h0000000;
      pulse_ack <= 1'b0;
    end else begin
      stby_prev <= pins.standby_ack;
      pulse_ack <= 1'b0;
      if (pins.standby_ack) begin
        stby_cnt <= (stby_cnt == ACK_SAT) ? stby_cnt : stby_cnt + 25'h0000001;
      end else begin
        stby_cnt <= 25'h0000000;
        pulse_ack <= stby_prev && pins.remote_priority && (stby_cnt >= ACK_LO) && (stby_cnt <= ACK_HI);
      end
    end
  end

  // Edge of pumping station acknowledges
  // Cause still present keeps its bit: set wins over the clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pump_prev <= 1'b0;
      err_pend <= 8'h00;
    end else begin
      pump_prev <= eff_cmd.pump_station;
      err_pend <= (ack ? 8'h00 : err_pend) | error_cause;
    end
  end

  // Drive outputs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      heating_on <= 1'b0;
      pump_motor_on <= 1'b0;
      speed_setpoint <= 10'h000;
      cooling_accessory_output <= 1'b0;
      vent_valve_accessory_output <= 1'b0;
    end else begin
      heating_on <= eff_cmd.heat;
      pump_motor_on <= eff_cmd.pump_station;
      speed_setpoint <= eff_cmd.standby ? stby_spd : pdr_pkg::FULL_SCALE;
      cooling_accessory_output <= eff_cmd.pump_station;
      case (vent_mode)
        pdr_pkg::VENT_ON_STOP: vent_valve_accessory_output <= eff_cmd.vent_enable && !eff_cmd.pump_station;
        pdr_pkg::VENT_ALWAYS: vent_valve_accessory_output <= eff_cmd.vent_enable;
        default: vent_valve_accessory_output <= 1'b0;
      endcase
    end
  end

  // Status outputs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      speed_point_output <= 1'b0;
      fault_free_output <= 1'b0;
      speed_analog_output <= 10'h000;
    end else begin
      speed_point_output <= do_value(do1_fn, rotor_speed >= switch_pt, any_err,
                                     pins.remote_priority, eff_cmd.heat, eff_cmd.pump_station);
      fault_free_output <= do_value(do2_fn, rotor_speed >= switch_pt, any_err,
                                    pins.remote_priority, eff_cmd.heat, eff_cmd.pump_station);
      case (ao_fn)
        pdr_pkg::AO_CURRENT: speed_analog_output <= motor_current;
        pdr_pkg::AO_POWER: speed_analog_output <= motor_power;
        default: speed_analog_output <= rotor_speed;
      endcase
    end
  end

  assign next_acc = 10'(adr_acc * 10'h00A) + 10'(rx_byte - pdr_pkg::ASCII_ZERO);

  // Address taken from three decimal digits after a telegram end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      adr_st <= pdr_pkg::ADR_D0;
      adr_acc <= 10'h000;
      addr_hit <= 1'b0;
    end else if (rx_strobe && !tx_busy) begin
      if (rx_byte == pdr_pkg::TELEGRAM_END) begin
        adr_st <= pdr_pkg::ADR_D0;
        adr_acc <= 10'h000;
      end else if (rx_byte < pdr_pkg::ASCII_ZERO || rx_byte > pdr_pkg::ASCII_NINE) begin
        adr_st <= pdr_pkg::ADR_WAIT;
      end else begin
        adr_acc <= next_acc;
        case (adr_st)
          pdr_pkg::ADR_D0: begin
            adr_st <= pdr_pkg::ADR_D1;
            addr_hit <= 1'b0;
          end
          pdr_pkg::ADR_D1: adr_st <= pdr_pkg::ADR_D2;
          pdr_pkg::ADR_D2: begin
            adr_st <= pdr_pkg::ADR_WAIT;
            addr_hit <= (next_acc == dev_addr) || (next_acc == pdr_pkg::GROUP_ADDR);
          end
          default: adr_st <= pdr_pkg::ADR_WAIT;
        endcase
      end
    end
  end

  // Own transmission echoes are ignored on the shared pair
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      if (rx_strobe && !tx_busy) begin
        rx_data <= rx_byte;
      end
      // New character wins over the read that clears the flag
      rx_valid <= (rx_strobe && !tx_busy) || (rx_valid && !(rd && addr == pdr_pkg::OFS_RX));
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rs485_tx <= 1'b1;
      rs485_drive_n <= 1'b1;
    end else begin
      rs485_tx <= tx_line;
      rs485_drive_n <= drive_n;
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    case (addr)
      pdr_pkg::OFS_CTRL: next_rdata = {12'h000, par_cmd};
      pdr_pkg::OFS_DI_CFG: next_rdata = {12'h000, di2_fn, di1_fn};
      pdr_pkg::OFS_DO_CFG: next_rdata = {8'h00, do2_fn, do1_fn};
      pdr_pkg::OFS_AO_CFG: next_rdata = {14'h0000, ao_fn};
      pdr_pkg::OFS_SWITCH_PT: next_rdata = {6'h00, switch_pt};
      pdr_pkg::OFS_STBY_SPD: next_rdata = {6'h00, stby_spd};
      pdr_pkg::OFS_VENT_MODE: next_rdata = {14'h0000, vent_mode};
      pdr_pkg::OFS_DEV_ADDR: next_rdata = {6'h00, dev_addr};
      pdr_pkg::OFS_STATUS: next_rdata = {5'h00, any_err, pins.remote_priority, pins, eff_cmd};
      pdr_pkg::OFS_ERR_PEND: next_rdata = {8'h00, err_pend};
      pdr_pkg::OFS_RX: next_rdata = {6'h00, addr_hit, rx_valid, rx_data};
      pdr_pkg::OFS_TX: next_rdata = {15'h0000, tx_busy};
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stand for one cycle only
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rd ? next_rdata : 16'h0000;
    end
  end
endmodule

// [test/pdr_monitor.sv]
// Port checker of the remote I/O block.
// Assumes default DI, DO and analog output functions.
`timescale 1ns/100ps
module pdr_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire pdr_pkg::pdr_pins_t remote_connector,
  input wire logic [9:0] rotor_speed,
  input wire logic [7:0] error_cause,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [9:0] speed_analog_output,
  input wire logic [9:0] speed_setpoint,
  input wire logic heating_on,
  input wire logic pump_motor_on,
  input wire logic cooling_accessory_output,
  input wire logic vent_valve_accessory_output,
  input wire logic fault_free_output,
  input wire logic rs485_tx,
  input wire logic rs485_drive_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // Seven cycles cover the pin synchroniser
  property p_heat; (remote_connector.remote_priority && remote_connector.heating_input)[*7] |-> heating_on; endproperty
  a_heat: assert property (p_heat) else $error("heating not on");
  property p_vent; (remote_connector.remote_priority && !remote_connector.venting_enable_input)[*7]
    |-> !vent_valve_accessory_output; endproperty
  a_vent: assert property (p_vent) else $error("vent valve while locked");
  property p_setpt; (remote_connector.remote_priority && !remote_connector.standby_ack)[*7]
    |-> speed_setpoint == pdr_pkg::FULL_SCALE; endproperty
  a_setpt: assert property (p_setpt) else $error("setpoint not nominal");
  property p_cool; cooling_accessory_output == pump_motor_on; endproperty
  a_cool: assert property (p_cool) else $error("cooling output wrong");
  property p_fault; error_cause != 8'h00 |-> ##2 !fault_free_output; endproperty
  a_fault: assert property (p_fault) else $error("fault not reported");
  property p_rdata; rdata != 16'h0000 |-> $past(rd); endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  property p_txidle; rs485_drive_n |-> rs485_tx; endproperty
  a_txidle: assert property (p_txidle) else $error("line not idle high");
  property p_ana; $stable(rotor_speed)[*3] |-> speed_analog_output == rotor_speed; endproperty
  a_ana: assert property (p_ana) else $error("analog output not speed");
  c_pump: cover property (pump_motor_on);
  c_fault: cover property (!fault_free_output);
  c_read: cover property (rd ##1 rdata != 16'h0000);
endmodule
bind pdr_top pdr_monitor mon (.mclk, .reset_n, .remote_connector, .rotor_speed, .error_cause, .rd, .rdata,
  .speed_analog_output, .speed_setpoint, .heating_on, .pump_motor_on, .cooling_accessory_output,
  .vent_valve_accessory_output, .fault_free_output, .rs485_tx, .rs485_drive_n);

// [test/pdr_ctrl_model.sv]
// External controller: command pins and serial characters.
// Assumes the drive synchronises both; line idles high by bias.
`timescale 1ns/100ps
module pdr_ctrl_model #(
  parameter int DIV = 16
) (
  input wire logic mclk,
  output pdr_pkg::pdr_pins_t pins,
  output logic rx
);
  initial begin
    pins = '0;
    rx = 1'b1;
  end
  task automatic set_pins(input pdr_pkg::pdr_pins_t p);
    @(posedge mclk);
    pins <= p;
  endtask
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      rx <= f[i];
      repeat (DIV - 1) @(posedge mclk);
    end
  endtask
endmodule

// [test/pdr_top_bench.sv]
// Self-checking bench of the remote I/O block.
// Assumes short ack and baud parameters; reads checked from a queue.
`timescale 1ns/100ps
module pdr_top_bench;
  logic mclk = 1'b0;
  logic reset_n, wr, rd, rd_d, spo, ffo, pmo;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [9:0] rotor_speed, setpt;
  logic [7:0] error_cause;
  logic coo, vvo, hto, txo, txdn;
  logic [9:0] aout, mcur, mpow;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'hA2E50207;
  int err_count = 0;
  int tests_run = 0;
  pdr_pkg::pdr_pins_t pins;
  logic rx;
  always #50 mclk = ~mclk;
  pdr_ctrl_model #(.DIV(16)) ctrl (.mclk(mclk), .pins(pins), .rx(rx));
  pdr_top #(.ACK_MIN_CYC(50), .ACK_MAX_CYC(200), .BAUD_DIV(16)) uut (.mclk(mclk), .reset_n(reset_n),
    .remote_connector(pins), .rs485_rx(rx), .rotor_speed(rotor_speed), .motor_current(mcur),
    .motor_power(mpow), .error_cause(error_cause), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .speed_point_output(spo), .fault_free_output(ffo), .cooling_accessory_output(coo),
    .vent_valve_accessory_output(vvo), .speed_analog_output(aout), .speed_setpoint(setpt), .heating_on(hto),
    .pump_motor_on(pmo), .rs485_tx(txo), .rs485_drive_n(txdn));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic a, input logic e);
    tests_run++;
    if (a !== e) begin
      err_count++;
      $display("mismatch %0t level %b exp %b", $time, a, e);
    end
  endtask
  task automatic chk_rd(input logic [15:0] e);
    tests_run++;
    if (rdata !== e) begin
      err_count++;
      $display("mismatch %0t rdata %h exp %h", $time, rdata, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  // Standby pin held n+1 cycles, then pending errors read
  task automatic pulse(input int n, input logic [15:0] e);
    ctrl.set_pins(5'h17);
    repeat (n) @(posedge mclk);
    ctrl.set_pins(5'h16);
    repeat (8) @(posedge mclk);
    rd_reg(pdr_pkg::OFS_ERR_PEND, e);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    rd_d <= rd;
    if (rd_d)
      chk_rd(exp_q.pop_front());
  end
  initial begin
    #(100 * 20000);
    err_count++;
    complete_run();
  end
  initial begin
    logic [9:0] sp;
    logic [7:0] tel [3][3] = '{'{8'h30, 8'h30, 8'h31}, '{8'h39, 8'h36, 8'h31}, '{8'h30, 8'h30, 8'h32}};
    logic [15:0] rxe [3] = '{16'h0331, 16'h0331, 16'h0132};
    {reset_n, wr, rd, mcur, mpow, addr, wdata, rotor_speed, error_cause} = '0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd_reg(pdr_pkg::OFS_DI_CFG, 16'h0004);
    rd_reg(pdr_pkg::OFS_DO_CFG, 16'h0010);
    rd_reg(pdr_pkg::OFS_STBY_SPD, 16'h029B);
    rd_reg(4'hF, 16'h0000);
    sp = 10'(rnd() % 1001);
    wr_reg(pdr_pkg::OFS_SWITCH_PT, {6'h00, sp});
    rd_reg(pdr_pkg::OFS_SWITCH_PT, {6'h00, sp});
    for (int i = 0; i < 6; i++) begin
      rotor_speed <= 10'(rnd() % 1001);
      {mcur, mpow} <= 20'(rnd());
      repeat (4) @(posedge mclk);
      chk(spo, rotor_speed >= sp);
      chk(aout == rotor_speed, 1'b1);
    end
    // Priority, heating, station and standby pins high
    ctrl.set_pins(5'h17);
    repeat (8) @(posedge mclk);
    rd_reg(pdr_pkg::OFS_STATUS, 16'h0377);
    chk(setpt == 10'h29B, 1'b1);
    chk(hto, 1'b1);
    chk(coo, 1'b1);
    chk(vvo, 1'b0);
    error_cause <= 8'h04;
    @(posedge mclk);
    error_cause <= 8'h00;
    rd_reg(pdr_pkg::OFS_ERR_PEND, 16'h0004);
    pulse(10, 16'h0004);
    pulse(300, 16'h0004);
    pulse(100, 16'h0000);
    chk(ffo, 1'b1);
    error_cause <= 8'h04;
    @(posedge mclk);
    error_cause <= 8'h00;
    ctrl.set_pins(5'h1C);
    repeat (8) @(posedge mclk);
    chk(vvo, 1'b1);
    ctrl.set_pins(5'h16);
    repeat (8) @(posedge mclk);
    rd_reg(pdr_pkg::OFS_ERR_PEND, 16'h0000);
    // Without priority the register commands rule
    ctrl.set_pins(5'h03);
    wr_reg(pdr_pkg::OFS_CTRL, 16'h0000);
    repeat (8) @(posedge mclk);
    chk(pmo, 1'b0);
    chk(setpt == 10'h3E8, 1'b1);
    wr_reg(pdr_pkg::OFS_CTRL, 16'h0004);
    repeat (3) @(posedge mclk);
    chk(pmo, 1'b1);
    wr_reg(pdr_pkg::OFS_TX, 16'h00A5);
    repeat (3) @(posedge mclk);
    chk(txdn | txo, 1'b0);
    repeat (170) @(posedge mclk);
    chk(txdn & txo, 1'b1);
    for (int k = 0; k < 3; k++) begin
      ctrl.send(pdr_pkg::TELEGRAM_END);
      for (int j = 0; j < 3; j++)
        ctrl.send(tel[k][j]);
      repeat (20) @(posedge mclk);
      rd_reg(pdr_pkg::OFS_RX, rxe[k]);
    end
    repeat (3) @(posedge mclk);
    complete_run();
  end
endmodule
